// ### logic/dq_sync.sv
// three-stage synchroniser for the flash data pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module dq_sync (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic [`DATA_W-1:0] pin_in,
  output logic      [`DATA_W-1:0] level
);

  flash_pkg::sync_state_s s;
  flash_pkg::sync_state_s next_s;
  logic [`DATA_W-1:0]     agree;

  // a bit moves only when stages two and three agree
  always_comb begin
    agree    = ~(s.s2 ^ s.s3);
    next_s   = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.q  = (s.s2 & agree) | (s.q & ~agree);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.q;

endmodule
`default_nettype wire

// ### logic/flash_consts.svh
// timing, code and geometry constants for the flash host sequencer
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

`define ADDR_W 18
`define DATA_W 16

`define CLK_PERIOD_NS 50
`define WE_LOW_NS 100
`define WE_HIGH_NS 100
`define ACCESS_NS 100
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_HIGH_CYC ((`WE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LAT_CYC 4
`define READ_CYC (1 + `ACCESS_CYC + `SYNC_LAT_CYC)

`define PROG_TIME_US 40
`define PROG_TIMEOUT_CYC ((`PROG_TIME_US * 1000) / `CLK_PERIOD_NS)
`define DATA_VALID_US 1
`define SETTLE_CYC \
  ((`DATA_VALID_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_TIMEOUT_CYC 32'd4000000

`define PROG_CYCLES 4
`define ERASE_CYCLES 6
`define SECTOR_ERASE_CODE 16'h0030
`define BLOCK_ERASE_CODE 16'h0050
`define CHIP_ERASE_CODE 16'h0010
`define CHIP_ERASE_ADDR 18'h05555
`define SECTOR_WORDS_LOG2 11
`define BLOCK_WORDS_LOG2 15
`define ERASED_WORD 16'hffff
`define INV_STATUS_BIT 7
`define ALT_STATUS_BIT 6

`endif

// ### logic/flash_pkg.sv
// types shared by the flash host sequencer
`include "flash_consts.svh"
package flash_pkg;

  typedef enum logic [2:0] {
    op_read    = 3'h0,
    op_program = 3'h1,
    op_sector  = 3'h2,
    op_block   = 3'h3,
    op_chip    = 3'h4
  } op_e;

  typedef enum logic [2:0] {
    st_idle   = 3'h0,
    st_wsetup = 3'h1,
    st_wlow   = 3'h2,
    st_whigh  = 3'h3,
    st_read   = 3'h4,
    st_settle = 3'h5
  } ctl_state_e;

  typedef enum logic [1:0] {
    rd_user   = 2'h0,
    rd_pre    = 2'h1,
    rd_poll   = 2'h2,
    rd_verify = 2'h3
  } purpose_e;

  typedef enum logic [1:0] {
    status_ok         = 2'h0,
    status_timeout    = 2'h1,
    status_not_erased = 2'h2
  } status_e;

  typedef struct packed {
    ctl_state_e          st;
    op_e                 op;
    purpose_e            why;
    logic [2:0]          idx;
    logic [7:0]          cnt;
    logic [31:0]         tmr;
    logic [`ADDR_W-1:0]  taddr;
    logic [`DATA_W-1:0]  wdata;
    logic [`DATA_W-1:0]  rdata;
    logic                prev_ok;
    logic                prev6;
    logic                vn;
    logic                vfail;
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic                dq_oe;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  dq_out;
    logic                resp_valid;
    status_e             status;
  } host_state_s;

  typedef struct packed {
    logic [`DATA_W-1:0] s1;
    logic [`DATA_W-1:0] s2;
    logic [`DATA_W-1:0] s3;
    logic [`DATA_W-1:0] q;
  } sync_state_s;

endpackage

// ### logic/parallel_flash_write_erase_sequencer.sv
// host sequencer driving an asynchronous x16 parallel nor flash
// Function
// RULE1: write strobe low only with select low
// RULE2: address stable before strobe falls
// RULE3: data held past strobe rising edge
// RULE4: read with select, output enable low
// RULE5: program: three unlock cycles, then word
// RULE6: program finishes within forty microseconds
// RULE7: program only words still erased; code refuses only a word with a zero bit where the new data has a one
// RULE8: no commands during internal program
// RULE9: only status reads while busy
// RULE10: sector erase: six cycles, code, sector
// RULE11: block erase: six cycles, code, block
// RULE12: erase address and code on pulse six
// RULE13: no commands during sector, block erase
// RULE14: chip erase: code at fixed address
// RULE15: chip erase starts on sixth rising edge
// RULE16: polling starts after launching strobe edge
// RULE17: program: bit seven inverted until done
// RULE18: full word valid one microsecond later
// RULE19: erase: bit seven zero until done
// RULE20: polling valid after final cycle's rise
// RULE21: confirm completion with two more reads
// RULE22: alternating bit stops when done
// RULE23: bad unlock cycle aborts to read
// RULE24: unlock addresses and data are parameters
// RULE25: idle reads return stored word
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module parallel_flash_write_erase_sequencer #(
  parameter logic [31:0]               erase_timeout_cycles =
    `ERASE_TIMEOUT_CYC,
  parameter logic [2:0][`ADDR_W-1:0]   prog_unlock_addr = '0,
  parameter logic [2:0][`DATA_W-1:0]   prog_unlock_data = '0,
  parameter logic [4:0][`ADDR_W-1:0]   erase_unlock_addr = '0,
  parameter logic [4:0][`DATA_W-1:0]   erase_unlock_data = '0
) (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire flash_pkg::op_e      cmd_op,
  input  wire logic [`ADDR_W-1:0]  cmd_addr,
  input  wire logic [`DATA_W-1:0]  cmd_wdata,
  output logic                     resp_valid,
  output flash_pkg::status_e       resp_status,
  output logic      [`DATA_W-1:0]  resp_rdata,
  output logic                     busy,
  output logic                     flash_ce_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n,
  output logic      [`ADDR_W-1:0]  flash_addr,
  output logic      [`DATA_W-1:0]  flash_dq_out,
  output logic                     flash_dq_oe,
  input  wire logic [`DATA_W-1:0]  flash_dq_in
);

  localparam logic [7:0]  we_low_cyc  = 8'(`WE_LOW_CYC);
  localparam logic [7:0]  we_high_cyc = 8'(`WE_HIGH_CYC);
  localparam logic [7:0]  read_cyc    = 8'(`READ_CYC);
  localparam logic [7:0]  settle_cyc  = 8'(`SETTLE_CYC);
  localparam logic [31:0] prog_limit  = 32'(`PROG_TIMEOUT_CYC);
  localparam logic [2:0]  prog_last   = 3'(`PROG_CYCLES - 1);
  localparam logic [2:0]  erase_last  = 3'(`ERASE_CYCLES - 1);
  localparam logic [`ADDR_W-1:0] sector_mask =
    ~((`ADDR_W'(1) << `SECTOR_WORDS_LOG2) - `ADDR_W'(1));
  localparam logic [`ADDR_W-1:0] block_mask =
    ~((`ADDR_W'(1) << `BLOCK_WORDS_LOG2) - `ADDR_W'(1));

  flash_pkg::host_state_s s;
  flash_pkg::host_state_s next_s;
  logic [`DATA_W-1:0]     level;
  logic                   is_prog;
  logic [2:0]             last_idx;
  logic [31:0]            limit;
  logic [`DATA_W-1:0]     expect_word;
  logic                   bit7_ok;
  logic                   is_write;

  dq_sync u_sync (
    .clock  (clock),
    .nrst   (nrst),
    .pin_in (flash_dq_in),
    .level  (level)
  );

  // address of bus cycle idx of the command sequence
  function automatic logic [`ADDR_W-1:0] seq_addr(
    input flash_pkg::op_e     op,
    input logic [2:0]         idx,
    input logic [`ADDR_W-1:0] ta
  );
    if (op == flash_pkg::op_program) begin
      seq_addr = (idx == prog_last) ? ta : prog_unlock_addr[idx]; // [RULE5]
    end else if (idx != erase_last) begin
      seq_addr = erase_unlock_addr[idx]; // [RULE24]
    end else if (op == flash_pkg::op_sector) begin
      seq_addr = ta & sector_mask; // [RULE10]
    end else if (op == flash_pkg::op_block) begin
      seq_addr = ta & block_mask; // [RULE11]
    end else begin
      seq_addr = `CHIP_ERASE_ADDR; // [RULE14]
    end
  endfunction

  // data word of bus cycle idx of the command sequence
  function automatic logic [`DATA_W-1:0] seq_data(
    input flash_pkg::op_e     op,
    input logic [2:0]         idx,
    input logic [`DATA_W-1:0] wd
  );
    if (op == flash_pkg::op_program) begin
      seq_data = (idx == prog_last) ? wd : prog_unlock_data[idx]; // [RULE5]
    end else if (idx != erase_last) begin
      seq_data = erase_unlock_data[idx]; // [RULE24]
    end else if (op == flash_pkg::op_sector) begin
      seq_data = `SECTOR_ERASE_CODE; // [RULE10]
    end else if (op == flash_pkg::op_block) begin
      seq_data = `BLOCK_ERASE_CODE; // [RULE11]
    end else begin
      seq_data = `CHIP_ERASE_CODE; // [RULE14]
    end
  endfunction

  always_comb begin
    is_prog     = (s.op == flash_pkg::op_program);
    last_idx    = is_prog ? prog_last : erase_last;
    limit       = is_prog ? prog_limit : erase_timeout_cycles; // [RULE6]
    expect_word = is_prog ? s.wdata : `ERASED_WORD;
    bit7_ok     = is_prog
      ? (level[`INV_STATUS_BIT] == s.wdata[`INV_STATUS_BIT]) // [RULE17]
      : level[`INV_STATUS_BIT]; // [RULE19]
    next_s            = s;
    next_s.resp_valid = 1'b0;
    next_s.cnt        = s.cnt + 8'd1;
    next_s.tmr        = s.tmr + 32'd1;
    case (s.st)
      flash_pkg::st_idle: begin
        if (cmd_valid) begin
          next_s.op      = cmd_op;
          next_s.taddr   = cmd_addr;
          next_s.wdata   = cmd_wdata;
          next_s.idx     = 3'h0;
          next_s.cnt     = 8'h00;
          next_s.prev_ok = 1'b0;
          case (cmd_op)
            flash_pkg::op_read: begin
              next_s.st  = flash_pkg::st_read; // [RULE25]
              next_s.why = flash_pkg::rd_user;
            end
            flash_pkg::op_program: begin
              next_s.st  = flash_pkg::st_read; // [RULE7]
              next_s.why = flash_pkg::rd_pre;
            end
            default: begin
              next_s.st = flash_pkg::st_wsetup;
            end
          endcase
        end
      end
      flash_pkg::st_wsetup: begin
        next_s.st  = flash_pkg::st_wlow; // [RULE2]
        next_s.cnt = 8'h00;
      end
      flash_pkg::st_wlow: begin
        if (s.cnt == we_low_cyc - 8'd1) begin
          next_s.st  = flash_pkg::st_whigh; // [RULE3]
          next_s.cnt = 8'h00;
        end
      end
      flash_pkg::st_whigh: begin
        if (s.cnt == we_high_cyc - 8'd1) begin
          next_s.cnt = 8'h00;
          if (s.idx == last_idx) begin
            // launch done: poll from the final rising edge on
            next_s.st  = flash_pkg::st_read; // [RULE16] [RULE20] [RULE15]
            next_s.why = flash_pkg::rd_poll; // [RULE12]
            next_s.tmr = 32'h0;
          end else begin
            next_s.idx = s.idx + 3'h1;
            next_s.st  = flash_pkg::st_wsetup;
          end
        end
      end
      flash_pkg::st_read: begin
        if (s.cnt == read_cyc) begin
          next_s.cnt   = 8'h00;
          next_s.rdata = level;
          case (s.why)
            flash_pkg::rd_pre: begin
              if (|(~level & s.wdata)) begin
                next_s.st         = flash_pkg::st_idle; // [RULE7]
                next_s.resp_valid = 1'b1;
                next_s.status     = flash_pkg::status_not_erased;
              end else begin
                next_s.st = flash_pkg::st_wsetup;
              end
            end
            flash_pkg::rd_poll: begin
              next_s.prev_ok = 1'b1;
              next_s.prev6   = level[`ALT_STATUS_BIT];
              if (bit7_ok && s.prev_ok &&
                  level[`ALT_STATUS_BIT] == s.prev6) begin // [RULE22]
                next_s.st = flash_pkg::st_settle; // [RULE18]
              end else if (s.tmr >= limit) begin
                next_s.st         = flash_pkg::st_idle;
                next_s.resp_valid = 1'b1;
                next_s.status     = flash_pkg::status_timeout;
              end
            end
            flash_pkg::rd_verify: begin
              if (!s.vn) begin
                next_s.vn    = 1'b1; // [RULE21]
                next_s.vfail = (level != expect_word);
              end else if (s.vfail || level != expect_word) begin
                next_s.why     = flash_pkg::rd_poll; // [RULE21]
                next_s.prev_ok = 1'b0;
              end else begin
                next_s.st         = flash_pkg::st_idle;
                next_s.resp_valid = 1'b1;
                next_s.status     = flash_pkg::status_ok;
              end
            end
            default: begin
              next_s.st         = flash_pkg::st_idle;
              next_s.resp_valid = 1'b1;
              next_s.status     = flash_pkg::status_ok;
            end
          endcase
        end
      end
      flash_pkg::st_settle: begin
        if (s.cnt == settle_cyc - 8'd1) begin
          next_s.st    = flash_pkg::st_read; // [RULE18]
          next_s.why   = flash_pkg::rd_verify;
          next_s.cnt   = 8'h00;
          next_s.vn    = 1'b0;
          next_s.vfail = 1'b0;
        end
      end
      default: begin
        next_s.st = flash_pkg::st_idle;
      end
    endcase
    // pins follow the next state so they leave flip-flops
    is_write = next_s.st inside {flash_pkg::st_wsetup, flash_pkg::st_wlow,
                                 flash_pkg::st_whigh};
    next_s.ce_n  = !(is_write || next_s.st == flash_pkg::st_read);
    next_s.we_n  = (next_s.st != flash_pkg::st_wlow); // [RULE1]
    // output enable held high one cycle per read: turnaround, toggling
    next_s.oe_n  = !(next_s.st == flash_pkg::st_read &&
                     next_s.cnt != 8'h00); // [RULE4] [RULE9]
    next_s.dq_oe = is_write; // [RULE4]
    next_s.addr  = is_write
      ? seq_addr(next_s.op, next_s.idx, next_s.taddr) : next_s.taddr;
    next_s.dq_out = seq_data(next_s.op, next_s.idx, next_s.wdata);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s      <= '0;
      s.ce_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.we_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_ready    = (s.st == flash_pkg::st_idle); // [RULE8] [RULE13]
  assign busy         = (s.st != flash_pkg::st_idle);
  assign resp_valid   = s.resp_valid;
  assign resp_status  = s.status;
  assign resp_rdata   = s.rdata;
  assign flash_ce_n   = s.ce_n;
  assign flash_oe_n   = s.oe_n;
  assign flash_we_n   = s.we_n;
  assign flash_addr   = s.addr;
  assign flash_dq_out = s.dq_out;
  assign flash_dq_oe  = s.dq_oe;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_we_with_ce: assert property (!flash_we_n |-> !flash_ce_n) // [RULE1]
    else $error("write strobe low without chip select");
  chk_addr_setup: assert property ( // [RULE2]
    !flash_we_n |-> $stable(flash_addr) && $past(!flash_ce_n))
    else $error("address moved around falling strobe");
  chk_data_hold: assert property ( // [RULE3]
    $rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_out))
    else $error("data not held at rising strobe");
  chk_read_drive: assert property ( // [RULE4]
    !flash_oe_n |-> !flash_dq_oe && !flash_ce_n && flash_we_n)
    else $error("read cycle while driving data");
  chk_seq_length: assert property ( // [RULE5]
    $rose(s.st == flash_pkg::st_read && s.why == flash_pkg::rd_poll)
    |-> s.idx == (is_prog ? 3'd3 : 3'd5))
    else $error("launch after wrong number of cycles");
  chk_sector_code: assert property ( // [RULE10]
    $fell(flash_we_n) && s.op == flash_pkg::op_sector && s.idx == 3'd5
    |-> flash_dq_out == 16'h0030 && flash_addr[10:0] == 11'h000)
    else $error("bad sector erase final cycle");
  chk_block_code: assert property ( // [RULE11]
    $fell(flash_we_n) && s.op == flash_pkg::op_block && s.idx == 3'd5
    |-> flash_dq_out == 16'h0050 && flash_addr[14:0] == 15'h0000)
    else $error("bad block erase final cycle");
  chk_chip_code: assert property ( // [RULE14]
    $fell(flash_we_n) && s.op == flash_pkg::op_chip && s.idx == 3'd5
    |-> flash_dq_out == 16'h0010 && flash_addr == 18'h05555)
    else $error("bad chip erase final cycle");
  chk_quiet_busy: assert property ( // [RULE8]
    s.st inside {flash_pkg::st_settle, flash_pkg::st_read} &&
    s.why inside {flash_pkg::rd_poll, flash_pkg::rd_verify}
    |-> flash_we_n && !flash_dq_oe)
    else $error("write during internal operation");
  chk_prog_timeout: assert property ( // [RULE6]
    resp_valid && resp_status == flash_pkg::status_timeout && is_prog
    |-> $past(s.tmr) >= 32'd800)
    else $error("program timeout reported early");
  chk_settle_gap: assert property ( // [RULE18]
    $rose(s.st == flash_pkg::st_read && s.why == flash_pkg::rd_verify)
    |-> $past(s.st) == flash_pkg::st_settle && $past(s.cnt) == 8'd19)
    else $error("verify read before data valid interval");

  cov_prog_ok: cover property (resp_valid && is_prog &&
    resp_status == flash_pkg::status_ok);
  cov_erase_ok: cover property (resp_valid && s.op == flash_pkg::op_sector &&
    resp_status == flash_pkg::status_ok);
  cov_timeout: cover property (resp_valid &&
    resp_status == flash_pkg::status_timeout);
  cov_not_erased: cover property (resp_valid &&
    resp_status == flash_pkg::status_not_erased);

endmodule
`default_nettype wire

// ### sim/flash_model.sv
// behavioural model of the x16 parallel flash device
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module flash_model #(
  parameter logic [2:0][`ADDR_W-1:0] prog_addr  = '0,
  parameter logic [2:0][`DATA_W-1:0] prog_data  = '0,
  parameter logic [4:0][`ADDR_W-1:0] erase_addr = '0,
  parameter logic [4:0][`DATA_W-1:0] erase_data = '0
) (
  input  wire logic               ce_n,
  input  wire logic               oe_n,
  input  wire logic               we_n,
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic [`DATA_W-1:0] din,
  input  wire logic               din_oe,
  output logic      [`DATA_W-1:0] dq
);
  logic [`DATA_W-1:0] mem [int];
  logic [`ADDR_W-1:0] ha [$];
  logic [`DATA_W-1:0] hd [$];
  logic [`ADDR_W-1:0] la = '0;
  logic [`ADDR_W-1:0] tgt = '0;
  logic [`DATA_W-1:0] tdata = '0;
  logic [`DATA_W-1:0] v = '0;
  logic               busy = 1'b0;
  logic               is_er = 1'b0;
  logic               tog = 1'b0;
  logic               rd;
  realtime            settle_until = 0.0;
  int                 prog_ns = 3000;
  int                 erase_ns = 20000;
  int                 writes = 0;
  int                 strays = 0;
  int                 ignored = 0;
  int                 aborts = 0;

  assign rd = !ce_n && !oe_n;
  // released bus shows the inverse of the last word
  assign dq = (rd === 1'b1) ? v : ~v;

  function automatic logic [`DATA_W-1:0] word(input logic [`ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : `ERASED_WORD;
  endfunction

  always @(posedge rd) begin
    if (din_oe) strays++;
    if (busy) tog = ~tog;
    if (busy && !is_er)
      v = {~tdata[15:8], ~tdata[7], tog, ~tdata[5:0]};
    else if (busy) v = {8'h00, 1'b0, tog, 6'h00};
    else v = word(addr);
    if (!busy && !is_er && $realtime < settle_until)
      v = {~v[15:8], v[7], ~v[6:0]};
  end

  always @(negedge we_n) begin
    if (ce_n) strays++;
    else la = addr;
  end
  always @(posedge we_n) if (!ce_n) take(la, din);

  task automatic launch(input bit er, input logic [`ADDR_W-1:0] lo,
                        input int span, input logic [`DATA_W-1:0] d);
    busy = 1'b1;
    is_er = er;
    tgt = lo;
    tdata = d;
    ha.delete();
    hd.delete();
    fork
      begin
        #(er ? erase_ns : prog_ns);
        if (er && span == 0) mem.delete();
        else if (er) for (int i = 0; i < span; i++) mem.delete(int'(lo) + i);
        else mem[int'(lo)] = word(lo) & d;
        settle_until = $realtime + 1000.0;
        busy = 1'b0;
      end
    join_none
  endtask

  task automatic take(input logic [`ADDR_W-1:0] a,
                      input logic [`DATA_W-1:0] d);
    bit pp;
    bit ep;
    int s;
    writes++;
    if (busy) begin
      ignored++;
      return;
    end
    ha.push_back(a);
    hd.push_back(d);
    s = ha.size();
    pp = s <= 4;
    ep = s <= 6;
    for (int i = 0; i < s && i < 3; i++)
      if (ha[i] !== prog_addr[i] || hd[i] !== prog_data[i]) pp = 0;
    for (int i = 0; i < s && i < 5; i++)
      if (ha[i] !== erase_addr[i] || hd[i] !== erase_data[i]) ep = 0;
    if (pp && s == 4) launch(0, a, 1, d);
    else if (ep && s == 6 && d === `SECTOR_ERASE_CODE)
      launch(1, {a[17:11], 11'h000}, 2048, d);
    else if (ep && s == 6 && d === `BLOCK_ERASE_CODE)
      launch(1, {a[17:15], 15'h0000}, 32768, d);
    else if (ep && s == 6 && d === `CHIP_ERASE_CODE && a === `CHIP_ERASE_ADDR)
      launch(1, a, 0, d);
    else if (!(pp || ep) || s >= 6) begin
      aborts++;
      ha.delete();
      hd.delete();
    end
  endtask
endmodule
`default_nettype wire

// ### sim/parallel_flash_write_erase_sequencer_test.sv
// self-checking testbench for the flash host sequencer
`timescale 1ns/1ps
`default_nettype none
`include "flash_consts.svh"
module parallel_flash_write_erase_sequencer_test;
  // unlock codes: arbitrary values
  localparam logic [2:0][`ADDR_W-1:0] pua = {18'h00333, 18'h00222, 18'h00111};
  localparam logic [2:0][`DATA_W-1:0] pud = {16'h0033, 16'h0022, 16'h0011};
  localparam logic [4:0][`ADDR_W-1:0] eua =
    {18'h00aaa, 18'h00999, 18'h00888, 18'h00777, 18'h00666};
  localparam logic [4:0][`DATA_W-1:0] eud =
    {16'h00aa, 16'h0099, 16'h0088, 16'h0077, 16'h0066};
  localparam flash_pkg::status_e ok = flash_pkg::status_ok;
  localparam flash_pkg::status_e late = flash_pkg::status_timeout;

  logic               clock = 1'b0;
  logic               nrst = 1'b0;
  logic               cmd_valid = 1'b0;
  logic               cmd_ready;
  flash_pkg::op_e     cmd_op = flash_pkg::op_read;
  logic [`ADDR_W-1:0] cmd_addr = '0;
  logic [`DATA_W-1:0] cmd_wdata = '0;
  logic               resp_valid;
  flash_pkg::status_e resp_status;
  logic [`DATA_W-1:0] resp_rdata;
  logic               busy;
  logic               ce_n;
  logic               oe_n;
  logic               we_n;
  logic [`ADDR_W-1:0] f_addr;
  logic [`DATA_W-1:0] dq_out;
  logic               dq_oe;
  logic [`DATA_W-1:0] dq_in;
  flash_pkg::status_e got_st;
  logic [`DATA_W-1:0] got_rd;
  int                 mismatches = 0;
  int                 samples_checked = 0;
  int                 w0;

  always #25 clock = ~clock;

  parallel_flash_write_erase_sequencer #(
    .erase_timeout_cycles(32'd2000),
    .prog_unlock_addr(pua), .prog_unlock_data(pud),
    .erase_unlock_addr(eua), .erase_unlock_data(eud)
  ) u_dut (
    .clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .resp_valid(resp_valid),
    .resp_status(resp_status), .resp_rdata(resp_rdata), .busy(busy),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(f_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
    .flash_dq_in(dq_in)
  );

  flash_model #(
    .prog_addr(pua), .prog_data(pud), .erase_addr(eua), .erase_data(eud)
  ) u_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr), .din(dq_out),
    .din_oe(dq_oe), .dq(dq_in)
  );

  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input flash_pkg::op_e op, input logic [17:0] a,
                     input logic [15:0] d);
    int n;
    @(negedge clock);
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    chk("busy", 16'h0002, {14'h0000, busy, cmd_ready});
    n = 0;
    while (resp_valid !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    chk("response", 16'h0001, {15'h0000, resp_valid});
    chk("idle", 16'h0001, {14'h0000, busy, cmd_ready});
    got_st = resp_status;
    got_rd = resp_rdata;
  endtask

  task automatic rd_chk(input logic [17:0] a, input logic [15:0] exp);
    run(flash_pkg::op_read, a, 16'h0000);
    chk("read word", exp, got_rd);
  endtask

  task automatic t_program();
    rd_chk(18'h12345, `ERASED_WORD);
    w0 = u_flash.writes;
    run(flash_pkg::op_program, 18'h00100, 16'h5a3c);
    chk("prog status", 16'(ok), 16'(got_st));
    chk("prog verify", 16'h5a3c, got_rd);
    chk("prog cycles", 16'h0004, 16'(u_flash.writes - w0));
    chk("prog addr", 16'h0100, u_flash.tgt[15:0]);
    chk("prog data", 16'h5a3c, u_flash.tdata);
    rd_chk(18'h00100, 16'h5a3c);
    w0 = u_flash.writes;
    run(flash_pkg::op_program, 18'h00100, 16'ha5c3);
    chk("refused", 16'(flash_pkg::status_not_erased), 16'(got_st));
    chk("refused cycles", 16'h0000, 16'(u_flash.writes - w0));
    u_flash.prog_ns = 30000;
    run(flash_pkg::op_program, 18'h3ffff, 16'h0001);
    u_flash.prog_ns = 3000;
    chk("slow prog", 16'(ok), 16'(got_st));
    chk("slow verify", 16'h0001, got_rd);
  endtask

  task automatic t_erase(input flash_pkg::op_e op, input logic [17:0] a,
                         input logic [15:0] base, input logic [15:0] code);
    run(op, a, 16'h0000);
    chk("erase status", 16'(ok), 16'(got_st));
    chk("erase target", base, u_flash.tgt[15:0]);
    chk("erase code", code, u_flash.tdata);
  endtask

  task automatic t_erases();
    run(flash_pkg::op_program, 18'h00900, 16'h1234);
    run(flash_pkg::op_program, 18'h01000, 16'h4321);
    run(flash_pkg::op_program, 18'h08000, 16'h00f0);
    t_erase(flash_pkg::op_sector, 18'h00abc, 16'h0800, 16'h0030);
    rd_chk(18'h00900, `ERASED_WORD);
    rd_chk(18'h01000, 16'h4321);
    t_erase(flash_pkg::op_block, 18'h0abcd, 16'h8000, 16'h0050);
    rd_chk(18'h08000, `ERASED_WORD);
    rd_chk(18'h01000, 16'h4321);
    t_erase(flash_pkg::op_chip, 18'h00123, 16'h5555, 16'h0010);
    rd_chk(18'h01000, `ERASED_WORD);
    rd_chk(18'h3ffff, `ERASED_WORD);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (u_flash.busy && n < 5000) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic t_timeout();
    u_flash.prog_ns = 60000;
    run(flash_pkg::op_program, 18'h20000, 16'h0000);
    chk("stuck prog", 16'(late), 16'(got_st));
    wait_idle();
    u_flash.prog_ns = 3000;
    u_flash.erase_ns = 150000;
    run(flash_pkg::op_sector, 18'h00000, 16'h0000);
    chk("stuck erase", 16'(late), 16'(got_st));
    wait_idle();
    u_flash.erase_ns = 20000;
    chk("stray strobes", 16'h0000, 16'(u_flash.strays));
    chk("busy writes", 16'h0000, 16'(u_flash.ignored));
    chk("aborts", 16'h0000, 16'(u_flash.aborts));
  endtask

  initial begin
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    t_program();
    t_erases();
    t_timeout();
    print_verdict();
  end

  initial begin
    #(40000 * 50);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
